// *** inc/mce_pkg.sv ***
package mce_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] MCE_OFS_CONTROL_THREE = 8'h5D; // Control register
    localparam logic [7:0] MCE_OFS_EVENT_SOURCE = 8'h5E; // Event source, read only
    localparam logic [7:0] MCE_CTRL_RESET = 8'h00; // Control reset value
    localparam logic [2:0] MCE_EVT_RESET = 3'h0; // Event flags reset value
    // Control field positions
    localparam int MCE_CTRL_BYPASS_BIT = 7; // Offset bypass
    localparam int MCE_CTRL_OS_MSB = 6; // Sleep oversample select, top
    localparam int MCE_CTRL_OS_LSB = 4; // Sleep oversample select, bottom
    localparam int MCE_CTRL_REFSEL_BIT = 3; // Per-axis reference update
    // Event field positions
    localparam int MCE_EVT_THS_BIT = 2; // Threshold event
    localparam int MCE_EVT_VECM_BIT = 1; // Vector change event
    localparam int MCE_EVT_DRDY_BIT = 0; // New data
    // ----------------------------------------
    // Oversample table shape
    // ----------------------------------------
    localparam int MCE_OS_LOG2_MIN = 1; // Smallest ratio is 2
    localparam int MCE_OS_LOG2_TOP = 10; // Ratio 1024 at slowest rate, code 7
    localparam logic [10:0] MCE_OS_ONE = 11'h001; // Shift base for ratio
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic signed [15:0] x; // X axis
        logic signed [15:0] y; // Y axis
        logic signed [15:0] z; // Z axis
    } mce_vec_s;
endpackage : mce_pkg

// *** rtl/mce_mag_control_event_flags.sv ***
`timescale 1ns/1ps
// Operation
// - Bypass clear: stored offsets added to samples
// - Bypass set: samples output without offsets
// - Control bits 6:4 select sleep oversampling
// - Oversample ratio from code and rate
// - Select clear: threshold fire updates all references
// - Select set: only firing axis reference updates
// - Event bit 2 flags threshold event
// - Event bit 1 flags vector change
// - Event bit 0 flags new sample
// - Distance above threshold longer than count
// - Zero references give absolute magnitude threshold
// - Vector references never readable by registers
// - Latch holds vector flag until read
module mce_mag_control_event_flags #(
    parameter int CNT_W = 8
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // Register port from serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // Raw sample input
    input wire logic sample_valid,
    input mce_pkg::mce_vec_s sample_raw,
    input mce_pkg::mce_vec_s hard_iron_offset,
    // Rate and oversample
    input wire logic [2:0] output_sample_rate,
    output logic [10:0] oversample_ratio,
    // Threshold detector link
    input wire logic ths_fire,
    input wire logic [2:0] ths_axis,
    output mce_pkg::mce_vec_s ths_ref,
    // Vector change configuration
    input wire logic vecm_enable,
    input wire logic vecm_latch_en,
    input wire logic vecm_ref_update_en,
    input wire logic [15:0] vecm_threshold,
    input wire logic [CNT_W-1:0] vecm_count,
    // Corrected output
    output mce_pkg::mce_vec_s mag_out
);
    import mce_pkg::*;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Saturating add of offset to sample
    function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                   input logic signed [15:0] b);
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s > 17'sh07FFF) begin
            sat_add = 16'sh7FFF;
        end else if (s < -17'sh08000) begin
            sat_add = -16'sh8000;
        end else begin
            sat_add = s[15:0];
        end
    endfunction : sat_add

    // Square of one axis difference
    function automatic logic [33:0] sq_diff(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
        logic signed [16:0] d;
        logic [16:0] m;
        d = 17'(a) - 17'(b);
        m = d[16] ? 17'(-d) : 17'(d);
        sq_diff = 34'(m) * 34'(m);
    endfunction : sq_diff

    // Ratio: log2 is top-by-code minus rate shift, floor of one
    function automatic logic [10:0] os_ratio(input logic [2:0] code, input logic [2:0] rate);
        int base;
        int shift;
        int l2;
        base = (code == 3'h0) ? MCE_OS_LOG2_TOP - 6 : MCE_OS_LOG2_TOP - 7 + int'(code);
        case (rate)
            3'h0: shift = 0;
            3'h1: shift = 2;
            3'h2: shift = 3;
            default: shift = int'(rate) + 2;
        endcase
        l2 = base - shift;
        if (l2 < MCE_OS_LOG2_MIN) begin
            l2 = MCE_OS_LOG2_MIN;
        end
        os_ratio = MCE_OS_ONE << l2;
    endfunction : os_ratio

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_ff; // Control register
    logic [7:0] rd_data_ff; // Read data
    logic ths_flag_ff; // Threshold flag
    logic vecm_flag_ff; // Vector change flag
    logic drdy_flag_ff; // New data flag
    logic eval_ff; // Output just updated, evaluate detector
    logic vecm_en_d_ff; // Enable delayed, for rise
    logic [CNT_W-1:0] above_cnt_ff; // Samples above threshold
    mce_vec_s vref_ff; // Hidden vector references
    mce_vec_s out_ff; // Corrected output
    mce_vec_s ths_ref_ff; // Threshold references
    logic [10:0] os_ff; // Oversample ratio

    // ----------------------------------------
    // Decode and datapath
    // ----------------------------------------
    wire ctrl_sel = (reg_addr == MCE_OFS_CONTROL_THREE); // Control addressed
    wire evt_sel = (reg_addr == MCE_OFS_EVENT_SOURCE); // Event addressed
    wire evt_read = reg_rd_en && evt_sel; // Clears flags
    wire bypass = ctrl_ff[MCE_CTRL_BYPASS_BIT]; // Offset bypass
    wire ref_sel = ctrl_ff[MCE_CTRL_REFSEL_BIT]; // Per-axis update
    wire [2:0] os_code = ctrl_ff[MCE_CTRL_OS_MSB:MCE_CTRL_OS_LSB];
    wire [7:0] evt_word = {5'h00, ths_flag_ff, vecm_flag_ff, drdy_flag_ff};
    // Reference registers never mux onto read data
    wire [7:0] rd_mux = ctrl_sel ? ctrl_ff : (evt_sel ? evt_word : 8'h00);
    mce_vec_s corr; // Sample after offset choice
    assign corr.x = bypass ? sample_raw.x : sat_add(sample_raw.x, hard_iron_offset.x);
    assign corr.y = bypass ? sample_raw.y : sat_add(sample_raw.y, hard_iron_offset.y);
    assign corr.z = bypass ? sample_raw.z : sat_add(sample_raw.z, hard_iron_offset.z);
    // Squared distance against squared threshold avoids a root
    wire [35:0] dist2 = 36'(sq_diff(out_ff.x, vref_ff.x)) + 36'(sq_diff(out_ff.y, vref_ff.y))
                      + 36'(sq_diff(out_ff.z, vref_ff.z));
    wire [35:0] ths2 = 36'(32'(vecm_threshold) * 32'(vecm_threshold)); // Threshold squared
    wire above = vecm_enable && (dist2 > ths2);
    wire cnt_top = (above_cnt_ff == {CNT_W{1'b1}}); // Counter saturated
    wire [CNT_W-1:0] nxt_above_cnt = above ? (cnt_top ? above_cnt_ff : above_cnt_ff + 1'b1)
                                           : '0; // Debounce count
    wire vecm_event = eval_ff && above && (nxt_above_cnt > vecm_count);
    wire vecm_live = above && (above_cnt_ff > vecm_count); // Condition now
    wire [2:0] ths_upd = ref_sel ? ths_axis : 3'h7;
    // Set beats clear in the read cycle
    wire nxt_ths_flag = ths_fire || (ths_flag_ff && !evt_read);
    wire nxt_drdy_flag = sample_valid || (drdy_flag_ff && !evt_read);
    wire nxt_vecm_flag = vecm_latch_en ? (vecm_event || (vecm_flag_ff && !evt_read))
                                       : (vecm_event || vecm_live);

    assign reg_rd_data = rd_data_ff;
    assign mag_out = out_ff;
    assign ths_ref = ths_ref_ff;
    assign oversample_ratio = os_ff;

    // ----------------------------------------
    // Register file and flags
    // ----------------------------------------
    // Writes to event source fall through unused
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= MCE_CTRL_RESET;
            rd_data_ff <= 8'h00;
            {ths_flag_ff, vecm_flag_ff, drdy_flag_ff} <= MCE_EVT_RESET;
            os_ff <= MCE_OS_ONE;
        end else if (ce) begin
            if (reg_wr_en && ctrl_sel) begin
                ctrl_ff <= reg_wr_data;
            end
            if (reg_rd_en) begin
                rd_data_ff <= rd_mux;
            end
            ths_flag_ff <= nxt_ths_flag;
            vecm_flag_ff <= nxt_vecm_flag;
            drdy_flag_ff <= nxt_drdy_flag;
            os_ff <= os_ratio(os_code, output_sample_rate);
        end
    end

    // ----------------------------------------
    // Output, references, detector
    // ----------------------------------------
    // Output on sample, detector one cycle later
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= '0;
            eval_ff <= 1'b0;
            vecm_en_d_ff <= 1'b0;
            above_cnt_ff <= '0;
            vref_ff <= '0;
        end else if (ce) begin
            eval_ff <= sample_valid;
            vecm_en_d_ff <= vecm_enable;
            if (sample_valid) begin
                out_ff <= corr;
            end
            if (eval_ff) begin
                above_cnt_ff <= nxt_above_cnt;
            end
            if (vecm_enable && !vecm_en_d_ff) begin
                vref_ff <= out_ff;
            end else if (vecm_event && vecm_ref_update_en) begin
                vref_ff <= out_ff;
            end
        end
    end

    // Threshold references, all or firing axis
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ths_ref_ff <= '0;
        end else if (ce && ths_fire) begin
            if (ths_upd[0]) ths_ref_ff.x <= out_ff.x;
            if (ths_upd[1]) ths_ref_ff.y <= out_ff.y;
            if (ths_upd[2]) ths_ref_ff.z <= out_ff.z;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_drdy_set;
        @(posedge clk_sys) disable iff (!rst_b) (ce && sample_valid) |=> drdy_flag_ff;
    endproperty
    a_drdy_set: assert property (p_drdy_set) else $error("drdy not set");
    property p_ths_set;
        @(posedge clk_sys) disable iff (!rst_b) (ce && ths_fire) |=> ths_flag_ff;
    endproperty
    a_ths_set: assert property (p_ths_set) else $error("ths flag not set");
    property p_evt_upper;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && reg_rd_en && evt_sel) |=> (reg_rd_data[7:3] == 5'h00);
    endproperty
    a_evt_upper: assert property (p_evt_upper) else $error("event upper bits set");
    property p_bypass;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && sample_valid && bypass) |=> (mag_out == $past(sample_raw));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output wrong");
    property p_offset;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && sample_valid && !bypass && sample_raw.x == 16'sh0000)
            |=> (mag_out.x == $past(hard_iron_offset.x));
    endproperty
    a_offset: assert property (p_offset) else $error("offset not applied");
    property p_ref_all;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && ths_fire && !ref_sel) |=> (ths_ref == $past(out_ff));
    endproperty
    a_ref_all: assert property (p_ref_all) else $error("refs not all updated");
    property p_ref_axis;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && ths_fire && ref_sel && !ths_axis[0]) |=> $stable(ths_ref.x);
    endproperty
    a_ref_axis: assert property (p_ref_axis) else $error("wrong axis updated");
    property p_latch_hold;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && vecm_latch_en && vecm_flag_ff && !evt_read) |=> vecm_flag_ff;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost");
    property p_os_fast;
        @(posedge clk_sys) disable iff (!rst_b)
            (ce && output_sample_rate == 3'h7) ##1 ce |-> (oversample_ratio == 11'h002);
    endproperty
    a_os_fast: assert property (p_os_fast) else $error("fast rate ratio not 2");
endmodule : mce_mag_control_event_flags

// *** test/mce_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module mce_host_model (
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // One write strobe; released bus shows inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask : wr
    // One read strobe; data taken after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rd_data;
    endtask : rd
endmodule : mce_host_model

// *** test/tb_mce_mag_control_event_flags.sv ***
`timescale 1ns/1ps
module tb_mce_mag_control_event_flags;
    import mce_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_sys, rst_b, sample_valid, ths_fire, vecm_enable, vecm_latch_en;
    logic reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, vecm_count;
    logic [2:0] output_sample_rate, ths_axis;
    logic [10:0] oversample_ratio;
    logic [15:0] vecm_threshold;
    mce_vec_s sample_raw, hard_iron_offset, ths_ref, mag_out;
    int n_errors = 0; // Mismatches
    int comparisons = 0; // Checks made
    int off[8] = '{0, 2, 3, 5, 6, 7, 8, 9}; // Log2 drop per rate step
    int lg; // Expected log2 ratio
    mce_host_model i_mce_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data));
    mce_mag_control_event_flags #(.CNT_W(8)) i_mce_mag_control_event_flags (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .sample_valid(sample_valid), .sample_raw(sample_raw),
        .hard_iron_offset(hard_iron_offset), .output_sample_rate(output_sample_rate),
        .oversample_ratio(oversample_ratio), .ths_fire(ths_fire), .ths_axis(ths_axis),
        .ths_ref(ths_ref), .vecm_enable(vecm_enable), .vecm_latch_en(vecm_latch_en),
        .vecm_ref_update_en(1'b0), .vecm_threshold(vecm_threshold),
        .vecm_count(vecm_count), .mag_out(mag_out));
    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Register read with expected value
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_mce_host_model.rd(a, d);
        chk({40'h0, d}, {40'h0, e});
    endtask : rdc
    // One raw sample, then time for the detector
    task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(negedge clk_sys);
        sample_raw = {x, y, z};
        sample_valid = 1'b1;
        @(negedge clk_sys);
        sample_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : smp
    // One threshold detector pulse
    task automatic fire(input logic [2:0] a);
        @(negedge clk_sys);
        ths_fire = 1'b1;
        ths_axis = a;
        @(negedge clk_sys);
        ths_fire = 1'b0;
        @(negedge clk_sys);
    endtask : fire
    // Counts and verdict
    task automatic give_verdict;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // Watchdog against a hang
    initial begin
        #100000;
        n_errors++;
        give_verdict;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        sample_valid = 1'b0;
        sample_raw = '0;
        hard_iron_offset = {16'h0010, 16'h0020, 16'h0030};
        output_sample_rate = 3'h0;
        ths_fire = 1'b0;
        ths_axis = 3'h0;
        vecm_enable = 1'b0;
        vecm_latch_en = 1'b1;
        vecm_threshold = 16'h000A;
        vecm_count = 8'h01;
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        chk(oversample_ratio, 11'h001);
        rdc(MCE_OFS_CONTROL_THREE, 8'h00);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h00);
        i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, 8'hFF);
        rdc(MCE_OFS_CONTROL_THREE, 8'hFF);
        i_mce_host_model.wr(MCE_OFS_EVENT_SOURCE, 8'hFF);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h00);
        rdc(8'h10, 8'h00);
        // Every code at every rate
        for (int r = 0; r < 8; r++) begin
            for (int c = 0; c < 8; c++) begin
                output_sample_rate = r[2:0];
                i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, {1'b0, c[2:0], 4'h0});
                repeat (2) @(negedge clk_sys);
                lg = (c > 1 ? c : 1) + 3 - off[r];
                lg = (lg < 1) ? 1 : lg;
                chk(oversample_ratio, MCE_OS_ONE << lg);
            end
        end
        // Offsets applied, then bypassed
        i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, 8'h00);
        smp(16'h0000, 16'h0002, 16'h0003);
        chk(mag_out, {16'h0010, 16'h0022, 16'h0033});
        rdc(MCE_OFS_EVENT_SOURCE, 8'h01);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h00);
        i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, 8'h80);
        smp(16'h0005, 16'h0006, 16'h0007);
        chk(mag_out, {16'h0005, 16'h0006, 16'h0007});
        // Threshold references: all axes, then one axis
        fire(3'h1);
        chk(ths_ref, {16'h0005, 16'h0006, 16'h0007});
        rdc(MCE_OFS_EVENT_SOURCE, 8'h05);
        i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, 8'h88);
        smp(16'h0009, 16'h000A, 16'h000B);
        fire(3'h2);
        chk(ths_ref, {16'h0005, 16'h000A, 16'h0007});
        // Vector change from zero references
        i_mce_host_model.wr(MCE_OFS_CONTROL_THREE, 8'h80);
        smp(16'h0000, 16'h0000, 16'h0000);
        vecm_enable = 1'b1;
        rdc(MCE_OFS_EVENT_SOURCE, 8'h05);
        smp(16'h0064, 16'h0000, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h01);
        smp(16'h0064, 16'h0000, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h03);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h00);
        // Distance exactly at threshold never fires
        smp(16'h0006, 16'h0008, 16'h0000);
        smp(16'h0006, 16'h0008, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h01);
        // Latch off: flag follows the condition, read leaves it
        vecm_latch_en = 1'b0;
        smp(16'h0064, 16'h0000, 16'h0000);
        smp(16'h0064, 16'h0000, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h03);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h02);
        smp(16'h0000, 16'h0000, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h01);
        // Non-zero references: only the change counts
        vecm_latch_en = 1'b1;
        vecm_enable = 1'b0;
        smp(16'h0100, 16'h0000, 16'h0000);
        vecm_enable = 1'b1;
        smp(16'h0100, 16'h0000, 16'h0000);
        smp(16'h0100, 16'h0000, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h01);
        smp(16'h0100, 16'h000B, 16'h0000);
        smp(16'h0100, 16'h000B, 16'h0000);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h03);
        // Reset in mid-run restores defaults
        @(negedge clk_sys);
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        chk(mag_out, 48'h0);
        chk(ths_ref, 48'h0);
        chk(oversample_ratio, 11'h001);
        rdc(MCE_OFS_CONTROL_THREE, 8'h00);
        rdc(MCE_OFS_EVENT_SOURCE, 8'h00);
        give_verdict;
    end
endmodule : tb_mce_mag_control_event_flags
